// ### logic/pbm_ctrl_status.sv
// Basic mode control and status registers with MII steering
//
// Notes on behaviour
// - Writing 1 to control bit 15 soft resets; reads 1 until done; restraps.
// - Control bit 14 loops MII transmit data back to MII receive.
// - Without auto-negotiation, control bit 13 selects 100 (1) or 10 Mb/s.
// - Bit 12 enables auto-negotiation; then bits 13 and 8 are ignored.
// - Speed, auto-negotiation enable and duplex reset from strap select.
// - Control bit 11 powers the port down; resets to 0.
// - Control bit 10 isolates port from MII, management still works.
// - Restart bit re-initiates negotiation; ignored while bit 12 is 0.
// - Restart reads 1 until started; early software clear changes nothing.
// - Without auto-negotiation, control bit 8 selects full (1) or half.
// - Collision test: COL follows TXEN within 512 / 4 bit times.
// - Control bits 6:0 are reserved, read 0, not writable.
// - Status reports no T4, but TX and 10BASE-T full and half abilities.
// - Status bits 10:7 read 0; software writes 0.
// - Status bit 6 reads 1: preamble suppression supported.
// - Status bit 5 is 1 once auto-negotiation completed; resets 0.
// - Control and status registers are 16 bits; upper half of the word reads 0.
module pbm_ctrl_status #(
	parameter int SOFT_HOLD = pbm_pkg::SOFT_RST_CYCLES
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	output logic                      irq,
	// Strap configuration
	input  wire logic [1:0]           autoneg_strap_select,
	// Auto-negotiation engine
	input  wire logic                 an_start_ack,
	input  wire logic                 an_complete,
	input  wire logic                 an_speed_100,
	input  wire logic                 an_full_duplex,
	output logic                      an_enable,
	output logic                      an_restart,
	// Port mode
	output logic                      phy_soft_rst,
	output logic                      port_speed_100,
	output logic                      port_full_duplex,
	output logic                      port_power_down,
	// MII side toward the MAC
	input  wire pbm_pkg::pbm_mii_s    mii_tx,
	output pbm_pkg::pbm_mii_s         mii_rx,
	output logic                      mii_col,
	output logic                      mii_crs,
	// Line side toward the transceiver
	output pbm_pkg::pbm_mii_s         line_tx,
	input  wire pbm_pkg::pbm_mii_s    line_rx,
	input  wire logic                 line_col,
	input  wire logic                 line_crs
);

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic wr_ctrl;
	logic wr_irq_stat;
	logic wr_irq_mask;

	assign wr_ctrl     = reg_wr && hit(reg_addr, pbm_pkg::OFF_CTRL);
	assign wr_irq_stat = reg_wr && hit(reg_addr, pbm_pkg::OFF_IRQ_STAT);
	assign wr_irq_mask = reg_wr && hit(reg_addr, pbm_pkg::OFF_IRQ_MASK);
	// status write ignored
	// No strobe is derived from OFF_STAT, so such writes fall away.

	// ****************************************
	// Soft reset
	// ****************************************
	logic soft_start;
	logic soft_busy;
	logic soft_reload;

	assign soft_start = wr_ctrl && reg_wdata[pbm_pkg::CB_RESET] && !soft_busy;

	pbm_soft_rst #(
		.HOLD_CYCLES (SOFT_HOLD)
	) u_soft_rst (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.start   (soft_start),
		.busy    (soft_busy),
		.reload  (soft_reload)
	);

	// ****************************************
	// Control fields
	// ****************************************
	logic             loopback;
	logic             power_down;
	logic             isolate;
	logic             col_test;
	logic             an_restart_pend;
	pbm_pkg::pbm_mode_s mode;
	logic             ctrl_wr_ok;

	// Writes during a soft reset are dropped: restrap would undo them anyway
	assign ctrl_wr_ok = wr_ctrl && !soft_busy;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload) begin
			mode <= pbm_pkg::strap_mode(autoneg_strap_select);
		end else if (ctrl_wr_ok) begin
			mode.speed_100   <= reg_wdata[pbm_pkg::CB_SPEED];
			mode.an_en       <= reg_wdata[pbm_pkg::CB_AN_EN];
			mode.full_duplex <= reg_wdata[pbm_pkg::CB_DUPLEX];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload)
			power_down <= 1'b0;
		else if (ctrl_wr_ok)
			power_down <= reg_wdata[pbm_pkg::CB_PWR_DOWN];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload)
			isolate <= 1'b0;
		else if (ctrl_wr_ok)
			isolate <= reg_wdata[pbm_pkg::CB_ISOLATE];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload)
			loopback <= 1'b0;
		else if (ctrl_wr_ok)
			loopback <= reg_wdata[pbm_pkg::CB_LOOPBACK];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload)
			col_test <= 1'b0;
		else if (ctrl_wr_ok)
			col_test <= reg_wdata[pbm_pkg::CB_COL_TEST];
	end

	// ****************************************
	// Auto-negotiation restart
	// ****************************************
	logic an_en_next;

	assign an_en_next = ctrl_wr_ok ? reg_wdata[pbm_pkg::CB_AN_EN] : mode.an_en;

	// pending until engine acknowledges; a written 0 is ignored
	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_reload)
			an_restart_pend <= 1'b0;
		else if (ctrl_wr_ok && reg_wdata[pbm_pkg::CB_AN_RST] && an_en_next)
			an_restart_pend <= 1'b1;
		else if (an_start_ack || !mode.an_en)
			an_restart_pend <= 1'b0;
	end

	// ****************************************
	// Effective port mode
	// ****************************************
	logic an_done_q;

	// completion only counts while negotiation is on
	always_ff @(posedge sys_clk) begin
		if (sys_rst || soft_busy)
			an_done_q <= 1'b0;
		else
			an_done_q <= an_complete && mode.an_en && !an_restart_pend;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			port_speed_100   <= 1'b0;
			port_full_duplex <= 1'b0;
		end else if (mode.an_en) begin
			port_speed_100   <= an_speed_100;
			port_full_duplex <= an_full_duplex;
		end else begin
			port_speed_100   <= mode.speed_100;
			port_full_duplex <= mode.full_duplex;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			an_enable       <= 1'b0;
			an_restart      <= 1'b0;
			phy_soft_rst    <= 1'b0;
			port_power_down <= 1'b0;
		end else begin
			an_enable       <= mode.an_en && !soft_busy;
			an_restart      <= an_restart_pend && !an_start_ack;
			phy_soft_rst    <= soft_busy;
			port_power_down <= power_down;
		end
	end

	// ****************************************
	// MII steering
	// ****************************************
	logic mii_quiet;
	logic line_quiet;

	// isolation silences the MII outputs here and the line transmit below
	assign mii_quiet  = isolate || power_down || soft_busy;
	assign line_quiet = power_down || soft_busy || loopback;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || mii_quiet) begin
			mii_rx  <= '0;
			mii_crs <= 1'b0;
		end else if (loopback) begin
			mii_rx  <= mii_tx;
			mii_crs <= mii_tx.en;
		end else begin
			mii_rx  <= line_rx;
			mii_crs <= line_crs || mii_tx.en;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || line_quiet || isolate)
			line_tx <= '0;
		else
			line_tx <= mii_tx;
	end

	// test collision mirrors TXEN one cycle later, well inside bounds
	always_ff @(posedge sys_clk) begin
		if (sys_rst || mii_quiet)
			mii_col <= 1'b0;
		else if (col_test)
			mii_col <= mii_tx.en;
		else
			mii_col <= line_col && !loopback && !port_full_duplex
			           && mii_tx.en;
	end

	// ****************************************
	// Interrupts
	// ****************************************
	logic [pbm_pkg::IRQ_W-1:0] irq_stat;
	logic [pbm_pkg::IRQ_W-1:0] irq_mask;
	logic [pbm_pkg::IRQ_W-1:0] irq_ev;
	logic                      an_done_d;

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			an_done_d <= 1'b0;
		else
			an_done_d <= an_done_q;
	end

	always_comb begin
		irq_ev = '0;
		irq_ev[pbm_pkg::EV_SOFT_DONE]  = soft_reload;
		irq_ev[pbm_pkg::EV_AN_DONE]    = an_done_q && !an_done_d;
		irq_ev[pbm_pkg::EV_AN_STARTED] = an_restart_pend && an_start_ack;
	end

	// Set beats a write-one clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			irq_stat <= '0;
		else if (wr_irq_stat)
			irq_stat <= (irq_stat & ~reg_wdata[pbm_pkg::IRQ_W-1:0]) | irq_ev;
		else
			irq_stat <= irq_stat | irq_ev;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			irq_mask <= pbm_pkg::IRQ_MASK_RST;
		else if (wr_irq_mask)
			irq_mask <= reg_wdata[pbm_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	// ****************************************
	// Read back
	// ****************************************
	logic [15:0] ctrl_view;
	logic [15:0] stat_view;

	always_comb begin
		ctrl_view = '0;
		ctrl_view[pbm_pkg::CB_RESET]    = soft_busy;
		ctrl_view[pbm_pkg::CB_LOOPBACK] = loopback;
		ctrl_view[pbm_pkg::CB_SPEED]    = mode.speed_100;
		ctrl_view[pbm_pkg::CB_AN_EN]    = mode.an_en;
		ctrl_view[pbm_pkg::CB_PWR_DOWN] = power_down;
		ctrl_view[pbm_pkg::CB_ISOLATE]  = isolate;
		ctrl_view[pbm_pkg::CB_AN_RST]   = an_restart_pend;
		ctrl_view[pbm_pkg::CB_DUPLEX]   = mode.full_duplex;
		ctrl_view[pbm_pkg::CB_COL_TEST] = col_test;
	end

	always_comb begin
		stat_view = pbm_pkg::STAT_FIXED;
		stat_view[pbm_pkg::SB_AN_DONE] = an_done_q;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !reg_rd)
			reg_rdata <= '0;
		else begin
			case (reg_addr)
				pbm_pkg::OFF_CTRL:     reg_rdata <= {16'h0000, ctrl_view};
				pbm_pkg::OFF_STAT:     reg_rdata <= {16'h0000, stat_view};
				pbm_pkg::OFF_IRQ_STAT:
					reg_rdata <= {29'h0000000, irq_stat};
				pbm_pkg::OFF_IRQ_MASK:
					reg_rdata <= {29'h0000000, irq_mask};
				default:               reg_rdata <= '0;
			endcase
		end
	end

endmodule

// ### logic/pbm_pkg.sv
// Package for the basic mode control and status register pair
package pbm_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL     = 8'h80;
	localparam logic [7:0] OFF_STAT     = 8'h84;
	localparam logic [7:0] OFF_IRQ_STAT = 8'hA0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hA4;

	localparam int REG_W = 16;

	// ****************************************
	// Control field positions
	// ****************************************
	localparam int CB_RESET    = 15;
	localparam int CB_LOOPBACK = 14;
	localparam int CB_SPEED    = 13;
	localparam int CB_AN_EN    = 12;
	localparam int CB_PWR_DOWN = 11;
	localparam int CB_ISOLATE  = 10;
	localparam int CB_AN_RST   = 9;
	localparam int CB_DUPLEX   = 8;
	localparam int CB_COL_TEST = 7;

	// ****************************************
	// Status field positions and fixed value
	// ****************************************
	localparam int SB_AN_DONE = 5;
	localparam logic [15:0] STAT_FIXED = 16'h7849;

	// ****************************************
	// Interrupt event bits
	// ****************************************
	localparam int IRQ_W          = 3;
	localparam int EV_SOFT_DONE   = 0;
	localparam int EV_AN_DONE     = 1;
	localparam int EV_AN_STARTED  = 2;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS           = 20;
	localparam int SOFT_RST_NS      = 320;
	localparam int SOFT_RST_CYCLES  = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_NS_100       = 10;
	localparam int COL_OFF_BITS     = 4;
	localparam int COL_OFF_MAX_CYC  = COL_OFF_BITS * BIT_NS_100 / CLK_NS;
	localparam int LOOP_DEAD_US     = 500;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic       en;
		logic       er;
		logic [3:0] d;
	} pbm_mii_s;

	typedef struct packed {
		logic speed_100;
		logic an_en;
		logic full_duplex;
	} pbm_mode_s;

	typedef enum logic [1:0] {
		SR_IDLE,
		SR_HOLD,
		SR_RELOAD
	} pbm_sr_e;

	// Strap select to reset mode
	function automatic pbm_mode_s strap_mode(input logic [1:0] sel);
		pbm_mode_s m;
		m = '{speed_100: 1'b0, an_en: 1'b0, full_duplex: 1'b0};
		case (sel)
			2'h0: m = '{speed_100: 1'b0, an_en: 1'b0, full_duplex: 1'b0};
			2'h1: m = '{speed_100: 1'b0, an_en: 1'b0, full_duplex: 1'b1};
			2'h2: m = '{speed_100: 1'b1, an_en: 1'b0, full_duplex: 1'b0};
			default: m = '{speed_100: 1'b1, an_en: 1'b1, full_duplex: 1'b1};
		endcase
		return m;
	endfunction

endpackage

// ### logic/pbm_soft_rst.sv
// Soft reset sequencer: holds the core in reset, then asks for a restrap
module pbm_soft_rst #(
	parameter int HOLD_CYCLES = pbm_pkg::SOFT_RST_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      reload
);

	localparam int CW = $clog2(HOLD_CYCLES + 1);

	pbm_pkg::pbm_sr_e state;
	logic [CW-1:0]    cnt;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= pbm_pkg::SR_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				pbm_pkg::SR_IDLE: begin
					if (start) begin
						state <= pbm_pkg::SR_HOLD;
						cnt   <= CW'(HOLD_CYCLES - 1);
					end
				end
				pbm_pkg::SR_HOLD: begin
					if (cnt == '0)
						state <= pbm_pkg::SR_RELOAD;
					else
						cnt <= cnt - 1'b1;
				end
				pbm_pkg::SR_RELOAD: state <= pbm_pkg::SR_IDLE;
				default: state <= pbm_pkg::SR_IDLE;
			endcase
		end
	end

	// Busy covers the reload cycle so the reset bit drops with restrap
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busy   <= 1'b0;
			reload <= 1'b0;
		end else begin
			busy   <= (state == pbm_pkg::SR_IDLE) ? start
			        : (state != pbm_pkg::SR_RELOAD);
			reload <= (state == pbm_pkg::SR_HOLD) && (cnt == '0);
		end
	end

endmodule

// ### test/pbm_an_model.sv
// Negotiation engine model that answers restart requests
module pbm_an_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Engine handshake
	input wire logic slow,
	input wire logic an_restart,
	output logic     an_start_ack,
	output logic     an_complete,
	output logic     an_speed_100,
	output logic     an_full_duplex
);
	logic [4:0] wait_cnt = 5'h0;
	logic [4:0] run_cnt = 5'h1F;

	// Result is 100 Mb/s full duplex, the same as the bench's first forced mode
	assign an_speed_100 = 1'b1;
	assign an_full_duplex = 1'b1;
	initial an_start_ack = 1'b0;
	initial an_complete = 1'b0;

	// Slow answers keep a restart pending across a software clear
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			wait_cnt <= 5'h0;
			run_cnt <= 5'h1F;
			an_start_ack <= 1'b0;
			an_complete <= 1'b0;
		end else begin
			an_start_ack <= an_restart && !an_start_ack
				&& (!slow || wait_cnt == 5'h0C);
			wait_cnt <= an_restart ? wait_cnt + 5'h1 : 5'h0;
			if (an_start_ack) begin
				run_cnt <= 5'h0;
				an_complete <= 1'b0;
			end else if (run_cnt != 5'h1F) begin
				run_cnt <= run_cnt + 5'h1;
			end
			if (run_cnt == 5'h08) begin
				an_complete <= 1'b1;
			end
		end
	end
endmodule

// ### test/pbm_ctrl_status_sva.sv
// Port checks for the basic mode control and status registers
module pbm_ctrl_status_sva #(
	parameter int SOFT_HOLD = pbm_pkg::SOFT_RST_CYCLES
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Engine and port mode
	input wire logic        an_start_ack,
	input wire logic        an_complete,
	input wire logic        an_restart,
	input wire logic        phy_soft_rst,
	input wire logic        port_speed_100,
	input wire logic        port_full_duplex,
	input wire logic        port_power_down
);
	// Soft reset output stands SOFT_HOLD + 1 cycles, both ends checked
	localparam int SR_TAIL = SOFT_HOLD - 1;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// ********
	// Sequences
	// ********
	// A write right behind another may fall in a soft reset window
	sequence s_wr;
		reg_wr && reg_addr == pbm_pkg::OFF_CTRL && !phy_soft_rst
			&& !$past(reg_wr);
	endsequence
	sequence s_wr_ctrl;
		s_wr ##0 !reg_wdata[15];
	endsequence

	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_stat;
		reg_rd && reg_addr == pbm_pkg::OFF_STAT
			|=> (reg_rdata & 32'hFFFFFFDF) == 32'h7849;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status fixed bits wrong");
	property p_ctrl_rsvd;
		reg_rd && reg_addr == pbm_pkg::OFF_CTRL |=> reg_rdata[6:0] == 7'h0;
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd)
		else $error("reserved control bits set");
	property p_an_done;
		reg_rd && reg_addr == pbm_pkg::OFF_STAT && !$past(an_complete)
			|=> !reg_rdata[5];
	endproperty
	a_an_done: assert property (p_an_done)
		else $error("negotiation done without engine");
	property p_soft;
		s_wr ##0 reg_wdata[15]
			|-> ##2 phy_soft_rst[*2] ##SR_TAIL phy_soft_rst ##1 !phy_soft_rst;
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset length wrong");
	property p_mode;
		s_wr_ctrl ##0 !reg_wdata[12] |-> ##2
			port_speed_100 == $past(reg_wdata[13], 2)
			&& port_full_duplex == $past(reg_wdata[8], 2);
	endproperty
	a_mode: assert property (p_mode)
		else $error("forced speed or duplex wrong");
	property p_pd;
		s_wr_ctrl |-> ##2 port_power_down == $past(reg_wdata[11], 2);
	endproperty
	a_pd: assert property (p_pd)
		else $error("power down not following control");
	property p_rs_ign;
		s_wr_ctrl ##0 (reg_wdata[9] && !reg_wdata[12])
			|-> ##2 !an_restart[*3];
	endproperty
	a_rs_ign: assert property (p_rs_ign)
		else $error("restart without negotiation enable");
	property p_rs_go;
		s_wr_ctrl ##0 (reg_wdata[9] && reg_wdata[12]) ##1 !an_start_ack
			|=> an_restart;
	endproperty
	a_rs_go: assert property (p_rs_go)
		else $error("restart request missing");
endmodule

// ### test/testbench.sv
// Self-checking bench for the basic mode control and status registers
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 2;
	localparam logic [31:0] MODES [6] = '{32'h2100, 32'h0000, 32'h4000,
		32'h0800, 32'h0400, 32'h0080};
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic [7:0]        reg_addr = 8'h00;
	logic [31:0]       reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [31:0]       reg_rdata, rnd, v;
	logic [1:0]        autoneg_strap_select = 2'h3;
	logic              irq, an_start_ack, an_complete, an_speed_100;
	logic              an_full_duplex, an_restart, phy_soft_rst, mii_col;
	logic              mii_crs, an_enable;
	logic              port_speed_100, port_full_duplex, port_power_down;
	logic              slow = 1'b0;
	logic              rd_q = 1'b0;
	logic              rnd_on = 1'b1;
	pbm_pkg::pbm_mii_s mii_tx = '0, line_rx = '0, mii_rx, line_tx, t_tx, t_rx;
	logic [63:0]       expq[$];
	logic [63:0]       head;
	int                fails = 0, n_tests = 0, seed = 32'h03F03F7A;

	pbm_ctrl_status #(.SOFT_HOLD(HOLD)) i_pbm_ctrl_status (.sys_clk,
		.sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
		.autoneg_strap_select, .an_start_ack, .an_complete, .an_speed_100,
		.an_full_duplex, .an_enable, .an_restart, .phy_soft_rst,
		.port_speed_100, .port_full_duplex, .port_power_down, .mii_tx,
		.mii_rx, .mii_col, .mii_crs, .line_tx, .line_rx,
		.line_col(1'b0), .line_crs(1'b0));
	pbm_an_model i_pbm_an_model (.sys_clk, .sys_rst, .slow, .an_restart,
		.an_start_ack, .an_complete, .an_speed_100, .an_full_duplex);

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (rnd_on) begin
			mii_tx <= 6'($random(seed));
			line_rx <= 6'($random(seed));
		end
	end

	// ********
	// Checking
	// ********
	task automatic miss(input string m);
		fails++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) miss($sformatf("pin %h want %h", g, e));
	endtask
	task automatic cmp_rd(input logic [31:0] g, input logic [63:0] h);
		n_tests++;
		if ((g & h[63:32]) !== h[31:0]) miss($sformatf("read %h", g));
	endtask
	always @(posedge sys_clk) begin
		if (rd_q) begin
			head = expq.pop_front();
			cmp_rd(reg_rdata, head);
		end
		rd_q <= reg_rd;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ********
	// Bus master
	// ********
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF);
		expq.push_back({m, e});
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wait_low(ref logic s);
		#1;
		repeat (60) begin
			if (s) begin
				@(posedge sys_clk);
				#1;
			end
		end
		cmp_pin(8'(s), 8'h0);
	endtask

	// Roughly 140 cycles of traffic; 20000 cycles, over a hundred times that, is a hang
	initial begin
		#400us;
		miss("watchdog");
		conclude();
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		idle(1);
		rd(pbm_pkg::OFF_CTRL, 32'h3100);
		rd(pbm_pkg::OFF_STAT, 32'h7849);
		wr(8'h88, 32'hFFFF);
		rd(8'h88, 32'h0);
		wr(pbm_pkg::OFF_STAT, $random(seed) & 32'hFFFFF87F);
		rd(pbm_pkg::OFF_STAT, 32'h7849);
		wr(pbm_pkg::OFF_IRQ_MASK, 32'h7);
		for (int i = 0; i < 2; i++) begin
			slow <= (i == 0);
			rnd = $random(seed);
			wr(pbm_pkg::OFF_CTRL, 32'h1200 | (rnd & 32'h7F));
			rd(pbm_pkg::OFF_CTRL, 32'h1200);
			wr(pbm_pkg::OFF_CTRL, 32'h1000);
			rd(pbm_pkg::OFF_CTRL, 32'h1200);
			idle(1);
			wait_low(an_restart);
			idle(12);
			rd(pbm_pkg::OFF_CTRL, 32'h1000);
			rd(pbm_pkg::OFF_STAT, 32'h7869);
			rd(pbm_pkg::OFF_IRQ_STAT, 32'h6);
			idle(1);
			#1;
			cmp_pin(8'({irq, port_speed_100, port_full_duplex, an_enable}),
				8'hF);
			wr(pbm_pkg::OFF_IRQ_STAT, 32'h7);
			idle(2);
			#1;
			cmp_pin(8'(irq), 8'h0);
		end
		foreach (MODES[k]) begin
			v = MODES[k];
			rnd = $random(seed);
			wr(pbm_pkg::OFF_CTRL, v | 32'h200 | (rnd & 32'h7F));
			rd(pbm_pkg::OFF_CTRL, v);
			// no descrambler here, so no dead time to wait out
			idle(3);
			#1;
			t_tx = mii_tx;
			t_rx = line_rx;
			@(posedge sys_clk);
			#1;
			cmp_pin(8'({port_speed_100, port_full_duplex, port_power_down,
				an_enable}),
				8'({v[13], v[8], v[11], 1'b0}));
			cmp_pin(8'(mii_crs), (v[11] | v[10]) ? 8'h0
				: 8'(t_tx.en));
			cmp_pin(8'(mii_rx), v[14] ? 8'(t_tx)
				: (v[11] | v[10]) ? 8'h0 : 8'(t_rx));
			cmp_pin(8'(line_tx), (v[14] | v[11] | v[10]) ? 8'h0
				: 8'(t_tx));
		end
		rnd_on <= 1'b0;
		mii_tx <= 6'h20;
		idle(2);
		#1;
		cmp_pin(8'(mii_col), 8'h1);
		mii_tx <= 6'h00;
		idle(2);
		#1;
		cmp_pin(8'(mii_col), 8'h0);
		autoneg_strap_select <= 2'h1;
		wr(pbm_pkg::OFF_CTRL, 32'h8000);
		rd(pbm_pkg::OFF_CTRL, 32'h8000, 32'h8000);
		idle(2);
		wait_low(phy_soft_rst);
		rd(pbm_pkg::OFF_CTRL, 32'h0100);
		rd(pbm_pkg::OFF_IRQ_STAT, 32'h1);
		idle(2);
		#1;
		cmp_pin(8'({port_speed_100, port_full_duplex, irq, an_enable}),
			8'h6);
		conclude();
	end
endmodule

bind pbm_ctrl_status pbm_ctrl_status_sva #(.SOFT_HOLD(SOFT_HOLD))
	i_pbm_ctrl_status_sva (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .an_start_ack, .an_complete,
	.an_restart, .phy_soft_rst, .port_speed_100, .port_full_duplex,
	.port_power_down);
